//--- logic/adc_link_pkg.sv
// Purpose: shared constants for the converter serial readout link
// Assumes: both ends run on mclk at 250 MHz
// Notes:   cycle counts are plain defaults, not device figures
package adc_link_pkg;
   localparam int unsigned WORD_BITS    = 16;
   localparam logic [4:0]  LAST_STEP    = 5'h10;
   localparam logic [15:0] RESET_CYCLES = 16'h0010;
   localparam logic [15:0] CONVERT_REQUEST_N_CYCLES  = 16'h00C8;
   localparam logic [15:0] RDY_LEAD     = 16'h0004;
   localparam logic [3:0]  DEV_HALF     = 4'h6;
   localparam logic [3:0]  HOST_HALF    = 4'h8;
   localparam logic [3:0]  CONVERT_REQUEST_N_HOLD    = 4'h6;
   // device input sync vector positions
   localparam int unsigned IN_MODE = 0;
   localparam int unsigned IN_CS   = 1;
   localparam int unsigned IN_CONVERT_REQUEST_N = 2;
   localparam int unsigned IN_SCLK = 3;
   localparam int unsigned IN_RST  = 4;
   // host register map, one word each
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam int unsigned CTRL_MASTER = 0;
   localparam int unsigned CTRL_CS_LOW = 1;
   localparam int unsigned CTRL_CONT   = 2;
   localparam int unsigned CTRL_START  = 3;
   localparam int unsigned CTRL_RESET  = 4;
   localparam logic [4:0]  CTRL_RESET_VALUE = 5'h00;
endpackage

//--- logic/adc_link_if.sv
// Purpose: pin bundle between converter port and its host
// Assumes: an undriven shared wire reads low
// Notes:   levels of the two-way pins are resolved here
interface adc_link_if;
   logic serial_mode_select;
   logic cs_n;
   logic convert_request_n;
   logic adc_reset_n;
   logic rdy_n;
   logic sdo_o;
   logic sdo_oe;
   logic serial_data_out;
   logic dev_sclk_o;
   logic dev_sclk_oe;
   logic host_sclk_o;
   logic host_sclk_oe;
   logic sclk;

   assign serial_data_out = sdo_oe & sdo_o;
   assign sclk = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe & host_sclk_o);

   modport dev (
      input  serial_mode_select,
      input  cs_n,
      input  convert_request_n,
      input  adc_reset_n,
      input  sclk,
      output rdy_n,
      output sdo_o,
      output sdo_oe,
      output dev_sclk_o,
      output dev_sclk_oe
   );
   modport host (
      output serial_mode_select,
      output cs_n,
      output convert_request_n,
      output adc_reset_n,
      output host_sclk_o,
      output host_sclk_oe,
      input  rdy_n,
      input  serial_data_out,
      input  sclk
   );
endinterface

//--- logic/adc_port_device.sv
// Purpose: converter side of the serial readout and conversion handshake
// Assumes: sample_word holds the result when a conversion ends
// Notes:   all link pins are resynchronised to mclk
//
// Local design decisions: the APB register port and the placing of the registers.
module adc_port_device (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   adc_link_if.dev          link,
   input  wire logic [15:0] sample_word,
   output logic             convert_request_n_done,
   output logic             convert_request_n_idle
);
   typedef enum logic [1:0] {st_reset, st_idle, st_convert_request_n} dev_state_e;

   dev_state_e  state_q;
   dev_state_e  state_d;
   logic [4:0]  in_s1_q;
   logic [4:0]  in_s2_q;
   logic        sclk_prev_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] word_q;
   logic [4:0]  bit_q;
   logic        shift_q;
   logic        pending_q;
   logic        rdy_n_q;
   logic        sdo_q;
   logic        sdo_oe_q;
   logic        sclk_q;
   logic        sclk_oe_q;
   logic [3:0]  div_q;
   logic        done_q;
   logic        idle_q;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // sclk stages start at its idle low level, so no false rise after reset
         in_s1_q     <= 5'h16;
         in_s2_q     <= 5'h16;
         sclk_prev_q <= 1'b0;
      end else begin
         in_s1_q     <= {link.adc_reset_n, link.sclk, link.convert_request_n,
                         link.cs_n, link.serial_mode_select};
         in_s2_q     <= in_s1_q;
         sclk_prev_q <= in_s2_q[adc_link_pkg::IN_SCLK];
      end
   end

   wire master    = in_s2_q[adc_link_pkg::IN_MODE];
   wire cs_low    = ~in_s2_q[adc_link_pkg::IN_CS];
   wire convert_request_n_low  = ~in_s2_q[adc_link_pkg::IN_CONVERT_REQUEST_N];
   wire pin_reset = ~in_s2_q[adc_link_pkg::IN_RST];
   wire host_rise = in_s2_q[adc_link_pkg::IN_SCLK] & ~sclk_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencing

   wire reset_end = (state_q == st_reset) && (cnt_q == adc_link_pkg::RESET_CYCLES);
   wire convert_request_n_end  = (state_q == st_convert_request_n) && (cnt_q == adc_link_pkg::CONVERT_REQUEST_N_CYCLES - 16'h0001);
   wire lead_hit  = (state_q == st_convert_request_n) &&
                    (cnt_q == adc_link_pkg::CONVERT_REQUEST_N_CYCLES - 16'h0001 - adc_link_pkg::RDY_LEAD);
   // a word still being shifted is never replaced, so the new result is lost
   wire load_now  = convert_request_n_end & ~shift_q;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + 16'h0001;
      unique case (state_q)
         st_reset: begin
            if (reset_end) begin
               state_d = st_idle;
            end
         end
         st_idle: begin
            cnt_d = 16'h0000;
            if (convert_request_n_low) begin
               state_d = st_convert_request_n;
            end
         end
         st_convert_request_n: begin
            if (convert_request_n_end) begin
               cnt_d   = 16'h0000;
               state_d = convert_request_n_low ? st_convert_request_n : st_idle;
            end
         end
      endcase
      if (pin_reset) begin
         state_d = st_reset;
         cnt_d   = 16'h0000;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= st_reset;
         cnt_q   <= 16'h0000;
         done_q  <= 1'b0;
         idle_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         done_q  <= convert_request_n_end;
         idle_q  <= (state_d == st_idle);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial output

   wire run_div  = shift_q & master & cs_low;
   wire div_wrap = run_div && (div_q == adc_link_pkg::DEV_HALF - 4'h1);
   wire div_rise = div_wrap & ~sclk_q;
   wire edge_x   = master ? div_rise : host_rise;
   // slave read begins on the first host rise after a load
   wire step     = edge_x & (shift_q | (~master & pending_q & cs_low));
   wire done     = step && (bit_q == adc_link_pkg::LAST_STEP);
   wire start_m  = load_now & master & cs_low;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         word_q    <= 16'h0000;
         bit_q     <= 5'h00;
         shift_q   <= 1'b0;
         pending_q <= 1'b0;
         sdo_q     <= 1'b0;
      end else begin
         if (load_now) begin
            word_q <= sample_word;
         end else if (step && !done) begin
            sdo_q  <= word_q[adc_link_pkg::WORD_BITS-1];
            word_q <= {word_q[14:0], 1'b0};
         end
         if (pin_reset || done) begin
            bit_q   <= 5'h00;
            shift_q <= 1'b0;
         end else if (start_m || step) begin
            shift_q <= 1'b1;
            bit_q   <= step ? bit_q + 5'h01 : 5'h00;
         end
         if (pin_reset || start_m || step) begin
            pending_q <= 1'b0;
         end else if (load_now) begin
            pending_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= 4'h0;
         sclk_q <= 1'b0;
      end else if (!run_div) begin
         // the closing rise still goes out; the clock drops one cycle later
         div_q  <= 4'h0;
         sclk_q <= 1'b0;
      end else if (div_wrap) begin
         div_q  <= 4'h0;
         sclk_q <= ~sclk_q;
      end else begin
         div_q  <= div_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ready and pin enables

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_n_q   <= 1'b1;
         sdo_oe_q  <= 1'b0;
         sclk_oe_q <= 1'b0;
      end else begin
         if (pin_reset) begin
            rdy_n_q <= 1'b1;
         end else if (reset_end) begin
            rdy_n_q <= 1'b0;
         end else if (load_now) begin
            rdy_n_q <= 1'b0;
         end else if (done) begin
            rdy_n_q <= 1'b1;
         end else if (lead_hit && !shift_q) begin
            // ready left low by reset or an unread word must rise before the load
            rdy_n_q <= 1'b1;
         end
         sdo_oe_q  <= cs_low;
         sclk_oe_q <= master & cs_low;
      end
   end

   assign link.rdy_n       = rdy_n_q;
   assign link.sdo_o       = sdo_q;
   assign link.sdo_oe      = sdo_oe_q;
   assign link.dev_sclk_o  = sclk_q;
   assign link.dev_sclk_oe = sclk_oe_q;
   assign convert_request_n_done        = done_q;
   assign convert_request_n_idle        = idle_q;
endmodule

//--- logic/adc_port_host.sv
// Purpose: host controller reading conversions, steered over apb
// Assumes: device pins reach this end through adc_link_if
// Notes:   one apb wait state on every access
module adc_port_host (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   adc_link_if.host         link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   logic [4:0]  ctrl_q;
   logic [2:0]  in_s1_q;
   logic [2:0]  in_s2_q;
   logic        sdo_s3_q;
   logic        rdy_prev_q;
   logic        sclk_prev_q;
   logic [3:0]  hold_q;
   logic        convert_request_n_req_q;
   logic        armed_q;
   logic        convert_request_n_neg_q;
   logic        rst_neg_q;
   logic        rd_q;
   logic [3:0]  div_q;
   logic        sclk_q;
   logic [4:0]  rise_q;
   logic [15:0] shreg_q;
   logic [15:0] data_q;
   logic        valid_q;
   logic        cs_n_q;
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   wire acc     = psel & penable & pready_q;
   wire wr      = acc & pwrite;
   wire hit_c   = (paddr == adc_link_pkg::REG_CTRL);
   wire hit_s   = (paddr == adc_link_pkg::REG_STATUS);
   wire hit_d   = (paddr == adc_link_pkg::REG_DATA);
   wire mapped  = hit_c | hit_s | hit_d;
   wire master  = ctrl_q[adc_link_pkg::CTRL_MASTER];
   // calibration access is safe only in slave mode with nothing running
   wire cal_ok  = ~master & ~rd_q & ~convert_request_n_req_q & ~rdy_prev_q;
   wire [31:0] status = {28'h0000000, cal_ok, rdy_prev_q, rd_q, valid_q};
   wire [31:0] rd_mux = hit_c ? {27'h0000000, ctrl_q} :
                        hit_s ? status :
                        hit_d ? {16'h0000, data_q} : 32'h00000000;
   wire start   = wr & hit_c & pwdata[adc_link_pkg::CTRL_START];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
         ctrl_q    <= adc_link_pkg::CTRL_RESET_VALUE;
      end else begin
         pready_q  <= psel & penable & ~pready_q;
         prdata_q  <= rd_mux;
         pslverr_q <= psel & penable & ~pready_q & ~mapped;
         if (wr && hit_c) begin
            ctrl_q <= pwdata[4:0] & 5'h17;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link inputs

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1_q     <= 3'h1;
         in_s2_q     <= 3'h1;
         sdo_s3_q    <= 1'b0;
         rdy_prev_q  <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         in_s1_q     <= {link.sclk, link.serial_data_out, link.rdy_n};
         in_s2_q     <= in_s1_q;
         sdo_s3_q    <= in_s2_q[1];
         rdy_prev_q  <= in_s2_q[0];
         sclk_prev_q <= in_s2_q[2];
      end
   end

   wire rdy_fall = rdy_prev_q & ~in_s2_q[0];
   wire dev_rise = master & in_s2_q[2] & ~sclk_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // convert request

   // one bank only: no new request while a slave read is still running
   wire go = start & ~rd_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q     <= 4'h0;
         convert_request_n_req_q <= 1'b0;
      end else if (go) begin
         hold_q     <= adc_link_pkg::CONVERT_REQUEST_N_HOLD;
         convert_request_n_req_q <= 1'b1;
      end else if (hold_q != 4'h0) begin
         hold_q     <= hold_q - 4'h1;
      end else begin
         convert_request_n_req_q <= ctrl_q[adc_link_pkg::CTRL_CONT];
      end
   end

   // the ready fall that ends reset carries no word: only a request arms a read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (convert_request_n_req_q) begin
         armed_q <= 1'b1;
      end else if (rdy_fall) begin
         armed_q <= 1'b0;
      end
   end

   wire slave_go = rdy_fall & ~master & armed_q;

   // convert and reset pins change on the falling mclk edge so that all devices agree
   always_ff @(negedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         convert_request_n_neg_q <= 1'b1;
         rst_neg_q  <= 1'b1;
      end else begin
         convert_request_n_neg_q <= ~convert_request_n_req_q;
         rst_neg_q  <= ~ctrl_q[adc_link_pkg::CTRL_RESET];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readout

   wire div_wrap = rd_q && (div_q == adc_link_pkg::HOST_HALF - 4'h1);
   wire own_rise = div_wrap & ~sclk_q;
   wire rd_end   = div_wrap & sclk_q && (rise_q == adc_link_pkg::LAST_STEP + 5'h01);
   // device sclk and data move together; take data from one stage earlier
   wire cap_bit  = master ? sdo_s3_q : in_s2_q[1];
   wire any_rise = master ? dev_rise : own_rise;
   wire m_last   = dev_rise && (rise_q == adc_link_pkg::LAST_STEP);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q    <= 1'b0;
         div_q   <= 4'h0;
         sclk_q  <= 1'b0;
         rise_q  <= 5'h00;
         shreg_q <= 16'h0000;
         data_q  <= 16'h0000;
         valid_q <= 1'b0;
         cs_n_q  <= 1'b1;
      end else begin
         if (slave_go) begin
            rd_q <= 1'b1;
         end else if (rd_end) begin
            rd_q <= 1'b0;
         end
         div_q  <= (!rd_q || div_wrap) ? 4'h0 : div_q + 4'h1;
         sclk_q <= (!rd_q || rd_end) ? 1'b0 : (div_wrap ? ~sclk_q : sclk_q);
         if (rdy_fall) begin
            rise_q <= 5'h00;
         end else if (any_rise && rise_q != adc_link_pkg::LAST_STEP + 5'h01) begin
            rise_q <= rise_q + 5'h01;
            if (rise_q != 5'h00) begin
               shreg_q <= {shreg_q[14:0], cap_bit};
            end
         end
         if (rd_end || m_last) begin
            data_q  <= rd_end ? shreg_q : {shreg_q[14:0], cap_bit};
            valid_q <= 1'b1;
         end else if (acc && !pwrite && hit_d) begin
            valid_q <= 1'b0;
         end
         cs_n_q <= ~(ctrl_q[adc_link_pkg::CTRL_CS_LOW] | rd_q | slave_go);
      end
   end

   assign link.serial_mode_select = master;
   assign link.cs_n               = cs_n_q;
   assign link.convert_request_n  = convert_request_n_neg_q;
   assign link.adc_reset_n        = rst_neg_q;
   assign link.host_sclk_o        = sclk_q;
   assign link.host_sclk_oe       = ~master;
   assign prdata                  = prdata_q;
   assign pready                  = pready_q;
   assign pslverr                 = pslverr_q;
endmodule

//--- tb/adc_link_props.sv
// Purpose: assertions on the pins between converter port and host
// Assumes: both ends on mclk, link pins resynchronised by the device
// Notes:   rise counter only tracks edges while ready is low
module adc_link_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic serial_mode_select,
   input wire logic cs_n,
   input wire logic convert_request_n,
   input wire logic adc_reset_n,
   input wire logic rdy_n,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic serial_data_out,
   input wire logic dev_sclk_oe,
   input wire logic host_sclk_oe,
   input wire logic sclk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sclk_q;
   logic       rise_now;
   logic [4:0] rise_cnt_q;
   logic [4:0] rise_cnt_d;
   ////////////////////////////////////////////////////////////////////
   // cleared while ready is high, so a pending-word blip counts zero
   assign rise_now   = sclk & ~sclk_q;
   assign rise_cnt_d = rdy_n ? 5'h00 : rise_cnt_q + {4'h0, rise_now};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q     <= 1'b0;
         rise_cnt_q <= 5'h00;
      end else begin
         sclk_q     <= sclk;
         rise_cnt_q <= rise_cnt_d;
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // four cycles cover the two sync flops and the output register
   a_data_float: assert property (cs_n [*4] |-> !sdo_oe && !serial_data_out)
      else $error("data line driven while deselected");
   a_clk_float: assert property ((serial_mode_select && cs_n) [*4] |-> !dev_sclk_oe)
      else $error("device clock driven while deselected");
   a_slave_clk: assert property (!serial_mode_select [*4] |-> !dev_sclk_oe)
      else $error("device drives clock in slave mode");
   a_host_clk_off: assert property (serial_mode_select [*2] |-> !host_sclk_oe)
      else $error("host drives clock in master mode");
   a_master_drives: assert property (serial_mode_select && !rdy_n && rise_cnt_q != 5'h00
      |-> dev_sclk_oe)
      else $error("master transfer without device clock");
   a_bit_stable: assert property (sdo_oe && $past(sdo_oe) && !sclk && !rdy_n
      && !$past(rdy_n) && !$past(rdy_n, 2) |-> $stable(sdo_o))
      else $error("data bit changed while clock low");
   a_word_edges: assert property ($rose(rdy_n) && adc_reset_n && $past(adc_reset_n, 4)
      && rise_cnt_q != 5'h00 |-> rise_cnt_q + {4'h0, rise_now}
      == adc_link_pkg::LAST_STEP + 5'h01)
      else $error("word ended after wrong edge count");
   a_read_owned: assert property (!rdy_n && adc_reset_n && rise_cnt_q != 5'h00
      && rise_cnt_q < adc_link_pkg::LAST_STEP |=> !rdy_n)
      else $error("ready released in mid word");
   a_convert_request_n_ready: assert property ($fell(convert_request_n) && adc_reset_n
      |-> ##[195:225] $fell(rdy_n))
      else $error("no ready fall after convert");
   a_reset_ready: assert property ($rose(adc_reset_n) |-> rdy_n [*8] ##[1:40] !rdy_n)
      else $error("ready did not fall after soft reset");
endmodule

//--- tb/adc_serial_readout_port_tb.sv
// Purpose: both ends joined, steered over apb, words checked end to end
// Assumes: one apb wait state, 200-cycle conversions
// Notes:   sample words are corner values first, then random
`define CHK(nm, ex, gt) begin \
   checked++; \
   if ((gt) !== (ex)) begin \
      bad_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
   end \
end
module adc_serial_readout_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] sample_word;
   logic [15:0] last_word;
   logic        convert_request_n_done;
   logic        convert_request_n_idle;
   logic [31:0] rdata;
   logic        rerr;
   logic [15:0] corner [3] = '{16'hFFFF, 16'h8001, 16'h0000};
   integer      seed;
   int          word_n = 0;
   int          cycles = 0;
   int          bad_count = 0;
   int          checked = 0;
   ////////////////////////////////////////////////////////////////////
   adc_link_if link ();
   adc_port_device adc_port_device_i (.mclk(mclk), .rst_n(rst_n), .link(link),
      .sample_word(sample_word), .convert_request_n_done(convert_request_n_done), .convert_request_n_idle(convert_request_n_idle));
   adc_port_host adc_port_host_i (.mclk(mclk), .rst_n(rst_n), .link(link), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   adc_link_props adc_link_props_i (.mclk(mclk), .rst_n(rst_n),
      .serial_mode_select(link.serial_mode_select), .cs_n(link.cs_n),
      .convert_request_n(link.convert_request_n), .adc_reset_n(link.adc_reset_n),
      .rdy_n(link.rdy_n), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
      .serial_data_out(link.serial_data_out), .dev_sclk_oe(link.dev_sclk_oe),
      .host_sclk_oe(link.host_sclk_oe), .sclk(link.sclk));
   ////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // next result is staged right after the previous one was taken
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         close_out();
      end
      if (convert_request_n_done === 1'b1) begin
         last_word   <= sample_word;
         word_n      <= word_n + 1;
         sample_word <= (word_n < 3) ? corner[word_n] : 16'($random(seed));
      end
   end
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] ctrl_word(input logic m, input logic c,
                                             input logic s, input logic r);
      ctrl_word = 32'h0;
      ctrl_word[adc_link_pkg::CTRL_MASTER] = m;
      ctrl_word[adc_link_pkg::CTRL_CS_LOW] = c;
      ctrl_word[adc_link_pkg::CTRL_START]  = s;
      ctrl_word[adc_link_pkg::CTRL_RESET]  = r;
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_status(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, adc_link_pkg::REG_STATUS, 32'h0);
         n++;
      end while (rdata[b] !== v && n < 400);
      `CHK("status bit", v, rdata[b])
   endtask
   task automatic close_out();
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      seed = 22158;
      sample_word = 16'h7FFE;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      rst_n = 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, adc_link_pkg::REG_CTRL, 32'h0);
      `CHK("ctrl reset", {27'h0, adc_link_pkg::CTRL_RESET_VALUE}, rdata)
      wait_status(2, 1'b0);
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("unmapped err", 1'b1, rerr)
      `CHK("unmapped data", 32'h0, rdata)
      apb(1'b1, 8'hFC, 32'($random(seed)));
      `CHK("unmapped wr err", 1'b1, rerr)
      // alternate slave and master reads, start bit must read back as 0
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, adc_link_pkg::REG_CTRL, ctrl_word(i[0], i[0], 1'b1, 1'b0));
         apb(1'b0, adc_link_pkg::REG_CTRL, 32'h0);
         `CHK("ctrl readback", ctrl_word(i[0], i[0], 1'b0, 1'b0), rdata)
         wait_status(0, 1'b1);
         apb(1'b0, adc_link_pkg::REG_DATA, 32'h0);
         `CHK("word", {16'h0, last_word}, rdata)
         apb(1'b0, adc_link_pkg::REG_STATUS, 32'h0);
         `CHK("valid cleared", 1'b0, rdata[0])
      end
      // deselected master: nothing moves, word stays pending
      apb(1'b1, adc_link_pkg::REG_CTRL, ctrl_word(1'b1, 1'b0, 1'b1, 1'b0));
      repeat (300) @(posedge mclk);
      apb(1'b0, adc_link_pkg::REG_STATUS, 32'h0);
      `CHK("no transfer", 1'b0, rdata[0])
      `CHK("pending ready", 1'b0, rdata[2])
      `CHK("convert_request_n idle", 1'b1, convert_request_n_idle)
      apb(1'b1, adc_link_pkg::REG_CTRL, ctrl_word(1'b1, 1'b1, 1'b1, 1'b0));
      wait_status(0, 1'b1);
      apb(1'b0, adc_link_pkg::REG_DATA, 32'h0);
      `CHK("newer word", {16'h0, last_word}, rdata)
      // soft reset holds ready high, release repeats the sequence
      apb(1'b1, adc_link_pkg::REG_CTRL, ctrl_word(1'b0, 1'b0, 1'b0, 1'b1));
      repeat (20) @(posedge mclk);
      apb(1'b0, adc_link_pkg::REG_STATUS, 32'h0);
      `CHK("ready in reset", 1'b1, rdata[2])
      apb(1'b1, adc_link_pkg::REG_CTRL, 32'h0);
      wait_status(2, 1'b0);
      `CHK("cal safe", 1'b1, rdata[3])
      close_out();
   end
endmodule
